// ---- src/wicd_command_decoder.sv ----
// Weld I/O terminal command decoder: serial ASCII commands read and write
// DAC values, scaling, routing, switch and relay masks and mode settings.
// Assumes synchronous inputs on sys_clk and an Avalon-MM master.
`include "wicd_params.svh"
`timescale 1ns/1ps
`default_nettype none

module wicd_command_decoder
   import wicd_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Terminal serial link.
   input wire logic serialRx,
   output logic serialTx,
   // Avalon-MM register slave.
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Measurements.
   input wire logic [10:0] analogInputOne,
   input wire logic [10:0] analogInputTwo,
   input wire logic encoderPulse,
   input wire logic [15:0] arcVoltageMeter,
   input wire logic [15:0] arcCurrentMeter,
   input wire logic [15:0] wireFeedMeter,
   input wire logic [15:0] gasFlowMeter,
   input wire logic [15:0] excitationCurrentReading,
   // Switches, pendant and weld state.
   input wire logic [7:0] switchInput,
   input wire logic [4:0] pendantKeys,
   input wire logic weldInProgress,
   input wire logic [3:0][15:0] paramValue,
   // Analog and network outputs.
   output logic [3:0][11:0] dacOut,
   output logic [3:0][3:0] netDevice,
   output logic [3:0][11:0] netValue,
   // Relays and switch functions.
   output logic [7:0] outputRelay,
   output logic [7:0] functionActive,
   // Axis network string forwarding.
   output logic [7:0] axisData,
   output logic axisValid,
   output logic [3:0] axisDevice,
   // Mode settings.
   output logic [15:0] sequenceNumberSelect,
   output logic simulationFlag,
   output logic [7:0] axisEnableMask,
   output logic [2:0] horizontalAxisId,
   output logic [2:0] verticalAxisId,
   output logic adaptiveControlDisable,
   output logic scheduleAutosaveDisable
);

   localparam int BitCycles = `WICD_CLK_HZ / `WICD_BAUD_RATE;
   localparam logic [11:0] BitLast = 12'(BitCycles - 1);
   localparam logic [11:0] BitHalf = 12'(BitCycles / 2 - 1);

   function automatic wicd_regs_t resetValue();
      wicd_regs_t r;
      r = '0;
      r.state = ST_IDLE;
      r.parserEn = `WICD_CTRL_RESET;
      r.txd = 1'b1;
      r.waitReq = 1'b1;
      r.mem[`WICD_IDX_HID] = `WICD_HID_RESET;
      r.mem[`WICD_IDX_VID] = `WICD_VID_RESET;
      return r;
   endfunction

   localparam wicd_regs_t RstVal = resetValue();

   function automatic logic isDigit(input logic [7:0] b);
      return (b >= 8'h30) && (b <= 8'h39);
   endfunction

   function automatic logic [15:0] pow10(input logic [2:0] k);
      case (k)
         3'h0: return 16'h2710;
         3'h1: return 16'h03E8;
         3'h2: return 16'h0064;
         3'h3: return 16'h000A;
         default: return 16'h0001;
      endcase
   endfunction

   // Maps a command letter and option to a store slot or a live source.
   function automatic wicd_dec_t decodeCmd(input logic [7:0] ltr, input logic [7:0] opt);
      wicd_dec_t d;
      d = '0;
      d.wr = 1'b1;
      case (ltr)
         8'h41: begin
            if (opt == 8'h00) begin
               d.ok = 1'b0;
            end else if (opt <= 8'h04) begin
               d.ok = 1'b1;
               d.idx = 6'(opt - 8'h01) + `WICD_IDX_DAC;
            end else if (opt <= 8'h06) begin
               d.ok = 1'b1;
               d.wr = 1'b0;
               d.roSel = 4'(opt - 8'h04);
            end else if (opt <= 8'h0E) begin
               d.ok = 1'b1;
               d.idx = 6'(opt - 8'h07) + `WICD_IDX_SLOPE;
            end else if (opt <= 8'h14) begin
               d.ok = 1'b1;
               d.wr = 1'b0;
               d.roSel = 4'(opt - 8'h0C);
            end else if (opt <= 8'h1E) begin
               d.ok = 1'b1;
               d.idx = 6'(opt - 8'h15) + `WICD_IDX_SEQREG;
            end
         end
         8'h43: begin
            d.ok = (opt <= 8'h05);
            d.idx = 6'(opt) + `WICD_IDX_CAL;
         end
         8'h44: begin
            d.ok = (opt >= 8'h01) && (opt <= 8'h04);
            d.idx = 6'(opt - 8'h01) + `WICD_IDX_ROUTE;
         end
         8'h49: begin
            d.ok = (opt <= 8'h07);
            d.idx = 6'(opt) + `WICD_IDX_INMASK;
         end
         8'h52: begin
            d.ok = (opt <= 8'h07);
            d.idx = 6'(opt) + `WICD_IDX_RLYMASK;
         end
         8'h4D: begin
            if (opt == 8'h00) begin
               d.ok = 1'b1;
               d.idx = `WICD_IDX_SEQNUM;
            end else if (opt == 8'h01) begin
               d.ok = 1'b1;
               d.wr = 1'b0;
               d.roSel = 4'h9;
            end else if (opt <= 8'h06) begin
               d.ok = 1'b1;
               d.idx = 6'(opt - 8'h02) + `WICD_IDX_RLYDRV;
            end else if ((opt == 8'h08) || (opt == 8'h09)) begin
               d.ok = 1'b1;
               d.idx = 6'(opt - 8'h08) + `WICD_IDX_ADIS;
            end
         end
         default: d.ok = 1'b0;
      endcase
      return d;
   endfunction

   wicd_regs_t c;
   wicd_regs_t n;
   logic [3:0][11:0] scaled;

   for (genvar p = 0; p < 4; p++) begin : gScale
      logic [31:0] prod;
      logic signed [33:0] sum;
      assign prod = paramValue[p] * c.mem[int'(`WICD_IDX_SLOPE) + p];
      assign sum = $signed({2'b00, prod}) + 34'($signed(c.mem[int'(`WICD_IDX_OFFSET) + p]));
      assign scaled[p] = sum[33] ? 12'h000 : ((|sum[32:12]) ? 12'hFFF : sum[11:0]);
   end

   always_comb begin
      wicd_dec_t dec;
      logic rxGo;
      logic [7:0] rxB;
      logic sendReq;
      logic [7:0] sendByte;
      logic encClr;
      logic [15:0] roVal;
      logic [15:0] wval;
      logic [7:0] keyRelays;
      logic [15:0] rt;
      n = c;
      dec = decodeCmd(c.letter, c.opt);
      rxB = c.rxShift;
      rxGo = c.rxDone && c.parserEn;
      sendReq = 1'b0;
      sendByte = 8'h00;
      encClr = 1'b0;
      roVal = 16'h0000;
      wval = c.val;
      keyRelays = 8'h00;
      rt = 16'h0000;
      n.rxDone = 1'b0;
      n.axisValid = 1'b0;
      n.waitReq = 1'b1;

      // Answer one cycle after the request; the low cycle completes it.
      if ((avs_read || avs_write) && c.waitReq) begin
         n.waitReq = 1'b0;
         case (avs_address)
            `WICD_OFS_STATUS: n.readData = {8'h00, c.rejCnt, c.letter, 7'h00,
                                            c.state != ST_IDLE};
            `WICD_OFS_CTRL: n.readData = {31'h0000_0000, c.parserEn};
            `WICD_OFS_ENCODER: n.readData = {16'h0000, c.encCnt};
            default: n.readData = 32'h0000_0000;
         endcase
      end
      if (avs_write && !c.waitReq && (avs_address == `WICD_OFS_CTRL) && avs_byteenable[0]) begin
         n.parserEn = avs_writedata[`WICD_CTRL_ENABLE_BIT];
         encClr = avs_writedata[`WICD_CTRL_ENCCLR_BIT];
      end

      n.encPrev = encoderPulse;
      n.encCnt = (encClr ? 16'h0000 : c.encCnt) + {15'h0000, encoderPulse && !c.encPrev};

      if (!c.rxBusy) begin
         if (!serialRx) begin
            n.rxBusy = 1'b1;
            n.rxCnt = BitHalf;
            n.rxBit = 4'h0;
         end
      end else if (c.rxCnt != 12'h000) begin
         n.rxCnt = c.rxCnt - 12'h001;
      end else begin
         n.rxCnt = BitLast;
         n.rxBit = c.rxBit + 4'h1;
         if (c.rxBit == 4'h0) begin
            n.rxBusy = !serialRx;
         end else if (c.rxBit <= 4'h8) begin
            n.rxShift = {serialRx, c.rxShift[7:1]};
         end else begin
            n.rxBusy = 1'b0;
            n.rxDone = serialRx;
         end
      end

      case (dec.roSel)
         4'h1: roVal = {5'h00, analogInputOne};
         4'h2: roVal = {5'h00, analogInputTwo};
         4'h3: roVal = c.encCnt;
         4'h4: roVal = arcVoltageMeter;
         4'h5: roVal = arcCurrentMeter;
         4'h6: roVal = wireFeedMeter;
         4'h7: roVal = gasFlowMeter;
         4'h8: roVal = excitationCurrentReading;
         4'h9: roVal = {8'h00, switchInput};
         default: roVal = 16'h0000;
      endcase

      if (rxGo && (rxB == `WICD_CHAR_CTRL_C)) begin
         n.state = ST_IDLE;
      end else begin
         case (c.state)
            ST_IDLE: begin
               if (rxGo && (rxB inside {8'h41, 8'h43, 8'h44, 8'h49, 8'h4C, 8'h4D, 8'h52})) begin
                  n.letter = rxB;
                  n.opt = 8'h00;
                  n.state = ST_OPT;
               end else if (rxGo && (rxB != `WICD_CHAR_CR)) begin
                  n.state = ST_DISCARD;
               end
            end
            ST_OPT: begin
               if (rxGo) begin
                  if (isDigit(rxB)) begin
                     n.opt = (c.opt > 8'h18) ? 8'hFF : 8'(c.opt * 8'h0A + {4'h0, rxB[3:0]});
                  end else if ((rxB == 8'h3D) && (c.letter == 8'h4C) &&
                               (c.opt >= 8'h01) && (c.opt <= 8'h08)) begin
                     n.axisDev = 4'(c.opt);
                     n.state = ST_AXIS;
                  end else if ((rxB == 8'h3D) && dec.ok && dec.wr) begin
                     n.val = 16'h0000;
                     n.state = ST_WDATA;
                  end else if ((rxB == 8'h3F) && dec.ok) begin
                     n.state = ST_QUERY;
                  end else if (rxB == `WICD_CHAR_CR) begin
                     n.rejCnt = c.rejCnt + 8'h01;
                     n.state = ST_IDLE;
                  end else begin
                     n.state = ST_DISCARD;
                  end
               end
            end
            ST_WDATA: begin
               if (rxGo) begin
                  if (isDigit(rxB)) begin
                     n.val = 16'(c.val * 16'h000A + {12'h000, rxB[3:0]});
                  end else if (rxB == `WICD_CHAR_CR) begin
                     n.state = ST_IDLE;
                     if ((dec.idx < `WICD_IDX_SLOPE) && (c.val > `WICD_DAC_MAX)) begin
                        wval = `WICD_DAC_MAX;
                     end
                     if (((dec.idx == `WICD_IDX_HID) || (dec.idx == `WICD_IDX_VID)) &&
                         ((c.val == 16'h0000) || (c.val > 16'h0004))) begin
                        n.rejCnt = c.rejCnt + 8'h01;
                     end else begin
                        n.mem[dec.idx] = wval;
                     end
                  end else begin
                     n.state = ST_DISCARD;
                  end
               end
            end
            ST_QUERY: begin
               if (rxGo && (rxB == `WICD_CHAR_CR)) begin
                  n.val = dec.wr ? c.mem[dec.idx] : roVal;
                  n.pw = 3'h0;
                  n.dig = 4'h0;
                  n.started = 1'b0;
                  n.state = ST_REPLY;
               end else if (rxGo) begin
                  n.state = ST_DISCARD;
               end
            end
            ST_AXIS: begin
               if (rxGo) begin
                  n.axisData = rxB;
                  n.axisValid = 1'b1;
                  if (rxB == `WICD_CHAR_CR) begin
                     n.state = ST_IDLE;
                  end
               end
            end
            ST_DISCARD: begin
               if (rxGo && (rxB == `WICD_CHAR_CR)) begin
                  n.rejCnt = c.rejCnt + 8'h01;
                  n.state = ST_IDLE;
               end
            end
            ST_REPLY: begin
               // Decimal digits by repeated subtraction, leading zeros skipped.
               if (c.val >= pow10(c.pw)) begin
                  n.val = c.val - pow10(c.pw);
                  n.dig = c.dig + 4'h1;
               end else if (c.txBits == 4'h0) begin
                  if ((c.dig != 4'h0) || c.started || (c.pw == 3'h4)) begin
                     sendReq = 1'b1;
                     sendByte = {4'h3, c.dig};
                     n.started = 1'b1;
                  end
                  n.dig = 4'h0;
                  n.pw = c.pw + 3'h1;
                  if (c.pw == 3'h4) begin
                     n.state = ST_REPLY_CR;
                  end
               end
            end
            ST_REPLY_CR: begin
               if (c.txBits == 4'h0) begin
                  sendReq = 1'b1;
                  sendByte = `WICD_CHAR_CR;
                  n.state = ST_IDLE;
               end
            end
            default: n.state = ST_IDLE;
         endcase
      end

      if (sendReq) begin
         n.txShift = {1'b1, sendByte, 1'b0};
         n.txBits = 4'hA;
         n.txCnt = BitLast;
      end else if (c.txBits != 4'h0) begin
         if (c.txCnt != 12'h000) begin
            n.txCnt = c.txCnt - 12'h001;
         end else begin
            n.txCnt = BitLast;
            n.txShift = {1'b1, c.txShift[9:1]};
            n.txBits = c.txBits - 4'h1;
         end
      end
      n.txd = (n.txBits != 4'h0) ? n.txShift[0] : 1'b1;

      for (int d = 0; d < 4; d++) begin
         n.dacOut[d] = c.mem[int'(`WICD_IDX_DAC) + d][11:0];
      end
      for (int p = 0; p < 4; p++) begin
         rt = c.mem[int'(`WICD_IDX_ROUTE) + p];
         n.netDev[p] = 4'h0;
         n.netVal[p] = scaled[p];
         if ((rt >= 16'h0001) && (rt <= 16'h0004)) begin
            n.dacOut[rt[1:0] - 2'h1] = scaled[p];
         end else if ((rt == 16'h0005) || (rt == 16'h0006)) begin
            n.netDev[p] = rt[3:0];
         end else if ((rt == 16'h0007) || (rt == 16'h0008)) begin
            n.netDev[p] = rt[3:0] - 4'h4;
         end
      end

      for (int f = 0; f < 8; f++) begin
         n.funcAct[f] = |(switchInput & c.mem[int'(`WICD_IDX_INMASK) + f][7:0]);
      end

      if (!weldInProgress) begin
         for (int k = 0; k < 5; k++) begin
            if (pendantKeys[k]) begin
               keyRelays = keyRelays |
                  c.mem[int'(`WICD_IDX_RLYMASK) + ((k == 0) ? 0 : k + 1)][7:0];
            end
         end
      end
      n.relay = c.mem[`WICD_IDX_RLYDRV][7:0] | keyRelays;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         c <= RstVal;
      end else begin
         c <= n;
      end
   end

   assign serialTx = c.txd;
   assign avs_readdata = c.readData;
   assign avs_waitrequest = c.waitReq;
   assign dacOut = c.dacOut;
   assign netDevice = c.netDev;
   assign netValue = c.netVal;
   assign outputRelay = c.relay;
   assign functionActive = c.funcAct;
   assign axisData = c.axisData;
   assign axisValid = c.axisValid;
   assign axisDevice = c.axisDev;
   assign sequenceNumberSelect = c.mem[`WICD_IDX_SEQNUM];
   assign simulationFlag = c.mem[`WICD_IDX_SIM][0];
   assign axisEnableMask = c.mem[`WICD_IDX_AXEN][7:0];
   assign horizontalAxisId = c.mem[`WICD_IDX_HID][2:0];
   assign verticalAxisId = c.mem[`WICD_IDX_VID][2:0];
   assign adaptiveControlDisable = c.mem[`WICD_IDX_ADIS][0];
   assign scheduleAutosaveDisable = c.mem[`WICD_IDX_SDIS][0];

endmodule // wicd_command_decoder

`default_nettype wire

// ---- shared/wicd_params.svh ----
// Constants of the weld I/O terminal command decoder: timing, register
// offsets, field positions, reset values and the parameter store layout.
// Assumes it is included by its bare name wherever the values are needed.
`ifndef WICD_PARAMS_SVH
`define WICD_PARAMS_SVH

`define WICD_CLK_HZ 25000000
`define WICD_BAUD_RATE 9600

`define WICD_OFS_STATUS 6'h00
`define WICD_OFS_CTRL 6'h04
`define WICD_OFS_ENCODER 6'h08
`define WICD_CTRL_ENABLE_BIT 0
`define WICD_CTRL_ENCCLR_BIT 1
`define WICD_CTRL_RESET 1'h1

`define WICD_CHAR_CR 8'h0D
`define WICD_CHAR_CTRL_C 8'h03
`define WICD_DAC_MAX 16'h0FFF

`define WICD_NREG 56
`define WICD_IDX_DAC 6'h00
`define WICD_IDX_SLOPE 6'h04
`define WICD_IDX_OFFSET 6'h08
`define WICD_IDX_SEQREG 6'h0C
`define WICD_IDX_CAL 6'h16
`define WICD_IDX_ROUTE 6'h1C
`define WICD_IDX_INMASK 6'h20
`define WICD_IDX_RLYMASK 6'h28
`define WICD_IDX_SEQNUM 6'h30
`define WICD_IDX_RLYDRV 6'h31
`define WICD_IDX_SIM 6'h32
`define WICD_IDX_AXEN 6'h33
`define WICD_IDX_HID 6'h34
`define WICD_IDX_VID 6'h35
`define WICD_IDX_ADIS 6'h36
`define WICD_IDX_SDIS 6'h37
`define WICD_HID_RESET 16'h0001
`define WICD_VID_RESET 16'h0002

`endif

// ---- shared/wicd_pkg.sv ----
// Types of the weld I/O terminal command decoder.
// Assumes wicd_params.svh sits on the include path.
`include "wicd_params.svh"

package wicd_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPT,
      ST_WDATA,
      ST_QUERY,
      ST_AXIS,
      ST_DISCARD,
      ST_REPLY,
      ST_REPLY_CR
   } wicd_state_t;

   typedef struct packed {
      logic ok;
      logic wr;
      logic [5:0] idx;
      logic [3:0] roSel;
   } wicd_dec_t;

   typedef struct packed {
      wicd_state_t state;
      logic [7:0] letter;
      logic [7:0] opt;
      logic [15:0] val;
      logic [2:0] pw;
      logic [3:0] dig;
      logic started;
      logic [`WICD_NREG-1:0][15:0] mem;
      logic [15:0] encCnt;
      logic encPrev;
      logic [7:0] rejCnt;
      logic parserEn;
      logic rxBusy;
      logic [11:0] rxCnt;
      logic [3:0] rxBit;
      logic [7:0] rxShift;
      logic rxDone;
      logic [11:0] txCnt;
      logic [3:0] txBits;
      logic [9:0] txShift;
      logic txd;
      logic waitReq;
      logic [31:0] readData;
      logic [3:0][11:0] dacOut;
      logic [3:0][3:0] netDev;
      logic [3:0][11:0] netVal;
      logic [7:0] relay;
      logic [7:0] funcAct;
      logic [7:0] axisData;
      logic axisValid;
      logic [3:0] axisDev;
   } wicd_regs_t;

endpackage

// ---- testbench/wicd_checker.sv ----
// Concurrent checks on the weld I/O command decoder's ports.
// Assumes it is bound to wicd_command_decoder and runs on one clock.
`timescale 1ns/1ps
`default_nettype none

module wicd_checker (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register bus.
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   // Serial line and settings.
   input wire logic serialTx,
   input wire logic [2:0] horizontalAxisId,
   input wire logic [2:0] verticalAxisId,
   input wire logic [3:0][3:0] netDevice,
   input wire logic axisValid,
   input wire logic [3:0] axisDevice
);
   logic [15:0] lowCnt_r;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // A low run on the reply line may only span whole bit times.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt_r <= 16'h0000;
      end else begin
         lowCnt_r <= serialTx ? 16'h0000 : lowCnt_r + 16'h0001;
      end
   end
   req_answer_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("Request was not answered in the next cycle.");
   ans_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("Answer stood longer than one cycle.");
   rdata_hold_a: assert property (avs_waitrequest |-> $stable(avs_readdata))
      else $error("Read data moved outside an answer.");
   ids_range_a: assert property (
      horizontalAxisId inside {[3'h1:3'h4]} && verticalAxisId inside {[3'h1:3'h4]})
      else $error("Axis identifier left its range.");
   id_default_a: assert property (
      $rose(rst_n) |-> horizontalAxisId == 3'h1 && verticalAxisId == 3'h2)
      else $error("Axis identifiers lost their defaults.");
   for (genvar g = 0; g < 4; g++) begin : gRoute
      net_code_a: assert property (
         netDevice[g] inside {4'h0, 4'h3, 4'h4, 4'h5, 4'h6})
         else $error("Network device code outside the route set.");
   end
   axis_pulse_a: assert property (
      axisValid |-> axisDevice inside {[4'h1:4'h8]} ##1 !axisValid)
      else $error("Axis byte pulse or device number wrong.");
   bit_time_a: assert property (
      $rose(serialTx) |-> lowCnt_r % 16'h0A2C == 16'h0000)
      else $error("Reply line low run is not whole bit times.");
endmodule // wicd_checker

bind wicd_command_decoder wicd_checker u_wicd_checker (.*);

`default_nettype wire

// ---- testbench/wicd_host_model.sv ----
// Host computer model: sends command bytes and collects reply bytes.
// Assumes the link bit time of 2604 clocks at 25 MHz.
`timescale 1ns/1ps
`default_nettype none

module wicd_host_model (
   // Clock.
   input wire logic sys_clk,
   // Serial lines as the host sees them.
   input wire logic hostRx,
   output logic hostTx
);
   logic [7:0] rxq[$];
   initial hostTx = 1'b1;
   task automatic sendByte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         hostTx <= f[i];
         repeat (16'h0A2B) @(posedge sys_clk);
      end
   endtask
   initial begin : rxLoop
      logic [7:0] b;
      forever begin
         @(negedge hostRx);
         repeat (16'h0F42) @(posedge sys_clk);
         for (int i = 0; i < 8; i++) begin
            b[i] = hostRx;
            repeat (16'h0A2C) @(posedge sys_clk);
         end
         rxq.push_back(b);
      end
   end
endmodule // wicd_host_model

`default_nettype wire

// ---- testbench/wicd_command_decoder_tb.sv ----
// Self-checking bench for the weld I/O terminal command decoder.
// Assumes the host model on the serial link and the bound checker.
`include "wicd_params.svh"
`timescale 1ns/1ps
`default_nettype none

module wicd_command_decoder_tb;
   logic sys_clk, serialRx, serialTx, avs_waitrequest, axisValid, simulationFlag;
   logic rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, encoderPulse = 1'b0;
   logic weldInProgress = 1'b0, adaptiveControlDisable, scheduleAutosaveDisable;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
   logic [3:0] avs_byteenable = 4'hF, axisDevice;
   logic [10:0] analogInputOne = 11'h100, analogInputTwo = 11'h200;
   logic [15:0] arcVoltageMeter = 16'h0011, arcCurrentMeter = 16'h0022;
   logic [15:0] wireFeedMeter = 16'h0033, gasFlowMeter = 16'h0044;
   logic [15:0] excitationCurrentReading = 16'h00C8, sequenceNumberSelect;
   logic [7:0] switchInput = 8'hA5, outputRelay, functionActive, axisData, axisEnableMask;
   logic [4:0] pendantKeys = 5'h00;
   logic [3:0][15:0] paramValue = 64'h0000_0000_0000_0000;
   logic [3:0][11:0] dacOut, netValue;
   logic [3:0][3:0] netDevice;
   logic [2:0] horizontalAxisId, verticalAxisId;
   logic [7:0] axq[$];
   int n_errors = 0, num_checks = 0;

   wicd_command_decoder u_wicd_command_decoder (.*);
   wicd_host_model u_wicd_host_model (.sys_clk(sys_clk), .hostRx(serialTx), .hostTx(serialRx));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (axisValid === 1'b1 && axisDevice === 4'h3) begin
         axq.push_back(axisData);
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   // The master holds its request until it samples waitrequest low.
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      chk("bus answer", 32'h0000_0001, {31'h0, n < 100});
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic cmd(input string s);
      for (int i = 0; i < s.len(); i++) u_wicd_host_model.sendByte(s[i]);
      u_wicd_host_model.sendByte(8'h0D);
      repeat (100) @(posedge sys_clk);
   endtask
   // Replies are decimal text; the value is rebuilt here to compare.
   task automatic ask(input string s, output logic [31:0] v);
      logic [7:0] b;
      v = 32'h0000_0000;
      b = 8'h00;
      u_wicd_host_model.rxq.delete();
      cmd(s);
      while (b !== 8'h0D) begin
         while (u_wicd_host_model.rxq.size() == 0) @(posedge sys_clk);
         b = u_wicd_host_model.rxq.pop_front();
         if (b !== 8'h0D) v = v * 32'h0000_000A + {24'h0, b - 8'h30};
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk("horizontal id", 32'h1, horizontalAxisId);
      chk("vertical id", 32'h2, verticalAxisId);
      chk("sequence number", 32'h0, sequenceNumberSelect);
      chk("simulation flag", 32'h0, simulationFlag);
      chk("disable flags", 32'h0, {adaptiveControlDisable, scheduleAutosaveDisable});
      chk("axis enables", 32'h0, axisEnableMask);
      chk("functions idle", 32'h0, functionActive);
      $display("reset test done");
      bus(1'b0, 6'h3C, 32'h0000_0000, rd);
      chk("unmapped read", 32'h0, rd);
      repeat (3) begin
         @(posedge sys_clk) encoderPulse <= 1'b1;
         @(posedge sys_clk) encoderPulse <= 1'b0;
      end
      repeat (3) @(posedge sys_clk);
      bus(1'b0, `WICD_OFS_ENCODER, 32'h0, rd);
      chk("encoder count", 32'h3, rd);
      bus(1'b1, `WICD_OFS_CTRL, 32'h0000_0003, rd);
      bus(1'b0, `WICD_OFS_ENCODER, 32'h0, rd);
      chk("encoder clear", 32'h0, rd);
      $display("bus test done");
      cmd("A1=5000");
      chk("dac one", 32'h0FFF, dacOut[0]);
      ask("A20?", rd);
      chk("excitation", 32'h0000_00C8, rd);
      ask("M1?", rd);
      chk("switch status", 32'h0000_00A5, rd);
      cmd("M5=9");
      chk("id kept", 32'h1, horizontalAxisId);
      bus(1'b0, `WICD_OFS_STATUS, 32'h0, rd);
      chk("rejects", 32'h1, rd[23:16]);
      cmd("M2=129");
      chk("relays", 32'h81, outputRelay);
      cmd("L3=M");
      chk("axis bytes", 32'h2, axq.size());
      chk("axis data", 32'h4D, axq[0]);
      paramValue <= 64'h0000_0000_0000_0100;
      cmd("A7=2");
      chk("scaled wire", 32'h0000_0200, netValue[0]);
      paramValue <= 64'h0000_0000_0000_0900;
      repeat (3) @(posedge sys_clk);
      chk("clamped wire", 32'h0000_0FFF, netValue[0]);
      cmd("D1=7");
      chk("wire route", 32'h0000_0003, netDevice[0]);
      $display("serial test done");
      results();
   end
   initial begin
      repeat (32'h001E_8480) @(posedge sys_clk);
      n_errors++;
      results();
   end
endmodule // wicd_command_decoder_tb

`default_nettype wire
